// ---- rtl/rtc_defs.svh ----
/*
  Constants of the real-time clock: register offsets, command and interrupt
  bit positions, reset values, counter limits and crystal rates.
  Assumes it is included once per file by its bare name.
*/
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the 5-bit bus)
// ----------------------------------------------------------------------
`define ADR_HUND        5'h00
`define ADR_HOUR        5'h01
`define ADR_MIN         5'h02
`define ADR_SEC         5'h03
`define ADR_MONTH       5'h04
`define ADR_DATE        5'h05
`define ADR_YEAR        5'h06
`define ADR_DOW         5'h07
`define ADR_ALARM_BASE  5'h08
`define ADR_ISTAT       5'h10
`define ADR_CMD         5'h11
`define ADR_IMASK       5'h12

// ----------------------------------------------------------------------
// Command bits
// ----------------------------------------------------------------------
`define CMD_TEST_BIT    5
`define CMD_IEN_BIT     4
`define CMD_RUN_BIT     3
`define CMD_24H_BIT     2
`define CMD_RST         8'h00

// ----------------------------------------------------------------------
// Interrupt status / mask layout
// ----------------------------------------------------------------------
`define IRQ_ALARM_BIT   0
`define IRQ_HUND_BIT    1
`define IRQ_TENTH_BIT   2
`define IRQ_SEC_BIT     3
`define IRQ_MIN_BIT     4
`define IRQ_HOUR_BIT    5
`define IRQ_DAY_BIT     6
`define STAT_ANY_BIT    7
`define IMASK_RST       8'h00
`define IRQ_SRC_W       7

// ----------------------------------------------------------------------
// Counter limits, PM offset, tick step and alarm ignore bits
// ----------------------------------------------------------------------
`define HUND_MAX        7'd99
`define HOUR_MAX        5'd23
`define MINSEC_MAX      6'd59
`define MONTH_MAX       4'd12
`define YEAR_MAX        7'd99
`define DOW_MAX         3'd6
`define HOUR_PM_OFS     5'd12
`define TICK_STEP       23'd100
`define ALARM_IGN_BIT   7
`define ALARM_HR_IGN    6

// ----------------------------------------------------------------------
// Crystal rates in Hz
// ----------------------------------------------------------------------
`define XTAL_HZ_32K     23'd32768
`define XTAL_HZ_1M      23'd1048576
`define XTAL_HZ_2M      23'd2097152
`define XTAL_HZ_4M      23'd4194304

`endif

// ---- rtl/rtc_pkg.sv ----
/*
  Types shared by the real-time clock modules.
  Assumes rtc_defs.svh carries all numeric constants.
*/
package rtc_pkg;

  // Crystal selection as written in command bits 1:0
  typedef enum logic [1:0] {
    XTAL_32K,
    XTAL_1M,
    XTAL_2M,
    XTAL_4M
  } xtal_sel_e;

  // Running time, binary, hours always kept 0..23
  typedef struct packed {
    logic [6:0] hund;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
    logic [3:0] month;
    logic [4:0] date;
    logic [6:0] year;
    logic [2:0] dow;
  } time_s;

  // Decoded command register
  typedef struct packed {
    logic      test;
    logic      ien;
    logic      run;
    logic      mode24;
    xtal_sel_e xtal;
  } cmd_s;

endpackage

// ---- rtl/rtc_prescaler.sv ----
/*
  Divides crystal-rate pulses down to a 100 Hz hundredths tick.
  Assumes OSC_TICK is a one-cycle pulse per crystal period, synchronous
  to the core clock and slower than it.
*/
`timescale 1ns/1ns
`include "rtc_defs.svh"

module rtc_prescaler
  import rtc_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      nrst_in,
  input  wire logic      osc_tick_in,
  input  wire xtal_sel_e xtal_in,
  input  wire logic      run_in,
  input  wire logic      test_in,
  output logic           tick_out
);

  logic [22:0] acc_reg;
  logic [22:0] acc_sum;
  logic [22:0] xtal_hz;
  logic        wrap;

  // Crystal rate lookup
  always_comb begin
    case (xtal_in)
      XTAL_32K: xtal_hz = `XTAL_HZ_32K;
      XTAL_1M:  xtal_hz = `XTAL_HZ_1M;
      XTAL_2M:  xtal_hz = `XTAL_HZ_2M;
      XTAL_4M:  xtal_hz = `XTAL_HZ_4M;
      default:  xtal_hz = `XTAL_HZ_32K;
    endcase
  end

  // Fractional divider: 32768 is no multiple of 100, so accumulate instead
  assign acc_sum = acc_reg + `TICK_STEP;
  assign wrap    = acc_sum >= xtal_hz;

  // Accumulator cleared while stopped so a restart begins a whole period
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_reg <= 23'h000000;
    end else if (!run_in) begin
      acc_reg <= 23'h000000;
    end else if (osc_tick_in) begin
      acc_reg <= wrap ? acc_sum - xtal_hz : acc_sum;
    end
  end

  // Test mode bypasses the divider to step counters per crystal pulse
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= run_in && osc_tick_in && (test_in || wrap);
    end
  end

endmodule

// ---- rtl/rtc_top.sv ----
/*
  Real-time clock with calendar, alarm and periodic interrupts, reached
  as an 8-bit classic Wishbone slave with an optional address latch.
  Assumes all inputs are synchronous to CORE_CLK_IN and OSC_TICK_IN is a
  one-cycle pulse per crystal period.
*/
`timescale 1ns/1ns
`include "rtc_defs.svh"

// Contract
// - 8-bit data, driven only on reads
// - Eight counters, each host writable and readable
// - Hundredths resolution, years 0 to 99
// - Counters stepped by divided crystal pulses
// - Address latch strobe plus direct addressing
// - Six selectable periodic interrupt rates
// - 51-bit alarm store, compare raises alarm
// - Status register shows alarm or periodic source
// - Power loss blocks access, timekeeping continues
// - Hundredths read latches all counters
// - Selectable 12 or 24 hour presentation
// - Calendar with leap-year February
// - Write-only command register with mode bits
// - Command bits 1:0 select crystal rate
// - Counter map from 00h, 12h PM flag
module rtc_top
  import rtc_pkg::*;
(
  input  wire logic       CORE_CLK_IN,
  input  wire logic       NRST_IN,
  input  wire logic       WB_CYC_IN,
  input  wire logic       WB_STB_IN,
  input  wire logic       WB_WE_IN,
  input  wire logic [4:0] WB_ADR_IN,
  input  wire logic [0:0] WB_SEL_IN,
  input  wire logic [7:0] WB_DAT_IN,
  output logic      [7:0] WB_DAT_OUT,
  output logic            WB_ACK_OUT,
  input  wire logic       ADDR_LATCH_IN,
  input  wire logic       OSC_TICK_IN,
  input  wire logic       PWR_FAIL_IN,
  output logic            IRQ_OUT,
  output logic            IRQ_ALARM_OUT
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  time_s       time_reg;
  time_s       time_next;
  time_s       hold_reg;
  cmd_s        cmd_reg;
  logic [7:0]  imask_reg;
  logic [6:0]  istat_reg;
  logic [6:0]  irq_ev;
  logic [4:0]  adr_latch_reg;
  logic [4:0]  adr_eff;
  logic        ack_reg;
  logic        req;
  logic        acc_ok;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rd_data;
  logic        tick;
  logic        adv_reg;
  logic        alarm_hit;
  logic [6:0]  alarm_val_reg [8];
  logic [7:0]  alarm_ign_reg;
  logic [6:0]  time_fld [8];
  logic [7:0]  fld_eq;
  logic [4:0]  hour_wr;
  logic [4:0]  date_max;
  logic        c_sec;
  logic        c_min;
  logic        c_hour;
  logic        c_day;
  logic        c_month;
  logic        c_year;

  // Width of each alarm field: hund, hour, min, sec, month, date, year, dow
  localparam logic [6:0] FLD_MASK [8] = '{7'h7F, 7'h1F, 7'h3F, 7'h3F,
                                          7'h0F, 7'h1F, 7'h7F, 7'h07};

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Internal 0..23 hour to host format; 12h gives 1..12 with bit 7 as PM
  function automatic logic [7:0] hour_fmt(input logic [4:0] h, input logic m24);
    logic [4:0] h12;
    h12 = (h > `HOUR_PM_OFS) ? h - `HOUR_PM_OFS : h;
    if (h == 5'd0) begin
      h12 = `HOUR_PM_OFS;
    end
    return m24 ? {3'b000, h} : {(h >= `HOUR_PM_OFS), 2'b00, h12};
  endfunction

  // Host hour byte back to internal 0..23
  function automatic logic [4:0] hour_parse(input logic [7:0] d, input logic m24);
    logic [4:0] h;
    h = (d[4:0] == `HOUR_PM_OFS) ? 5'd0 : d[4:0];
    return m24 ? d[4:0] : (d[7] ? h + `HOUR_PM_OFS : h);
  endfunction

  // Days in a month; two-digit years divisible by four are leap years
  function automatic logic [4:0] month_days(input logic [3:0] mo, input logic [6:0] yr);
    case (mo)
      4'd2:                      return (yr[1:0] == 2'b00) ? 5'd29 : 5'd28;
      4'd4, 4'd6, 4'd9, 4'd11:   return 5'd30;
      default:                   return 5'd31;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------
  // Latch strobe high passes the address; low holds the last one latched
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      adr_latch_reg <= 5'h00;
    end else if (ADDR_LATCH_IN) begin
      adr_latch_reg <= WB_ADR_IN;
    end
  end

  assign adr_eff = ADDR_LATCH_IN ? WB_ADR_IN : adr_latch_reg;
  assign req     = WB_CYC_IN && WB_STB_IN && !ack_reg;
  // Power loss still acks so the master never hangs, but nothing happens
  assign acc_ok  = req && !PWR_FAIL_IN;
  // Writes land at the edge where the master sees ack, its data still held
  assign wr_en   = WB_CYC_IN && WB_STB_IN && ack_reg && !PWR_FAIL_IN && WB_WE_IN && WB_SEL_IN[0];
  assign rd_en   = acc_ok && !WB_WE_IN;
  assign hour_wr = hour_parse(WB_DAT_IN, cmd_reg.mode24);

  // One-cycle ack, dropped the cycle after
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  assign WB_ACK_OUT = ack_reg;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Counters above hundredths come from the snapshot to avoid roll-over
  always_comb begin
    rd_data = 8'h00;
    if (adr_eff >= `ADR_ALARM_BASE && adr_eff < `ADR_ISTAT) begin
      rd_data = {alarm_ign_reg[adr_eff[2:0]], alarm_val_reg[adr_eff[2:0]]};
    end else begin
      case (adr_eff)
        `ADR_HUND:  rd_data = {1'b0, time_reg.hund};
        `ADR_HOUR:  rd_data = hour_fmt(hold_reg.hour, cmd_reg.mode24);
        `ADR_MIN:   rd_data = {2'b00, hold_reg.min};
        `ADR_SEC:   rd_data = {2'b00, hold_reg.sec};
        `ADR_MONTH: rd_data = {4'h0, hold_reg.month};
        `ADR_DATE:  rd_data = {3'b000, hold_reg.date};
        `ADR_YEAR:  rd_data = {1'b0, hold_reg.year};
        `ADR_DOW:   rd_data = {5'h00, hold_reg.dow};
        `ADR_ISTAT: rd_data = {(|istat_reg), istat_reg};
        `ADR_IMASK: rd_data = imask_reg;
        default:    rd_data = 8'h00; // Command register is write-only
      endcase
    end
  end

  // Data leaves only with the read ack; zero otherwise
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      WB_DAT_OUT <= 8'h00;
    end else begin
      WB_DAT_OUT <= rd_en ? rd_data : 8'h00;
    end
  end

  // Reading hundredths freezes every counter above hundredths for the following reads
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hold_reg <= '0;
    end else if (rd_en && adr_eff == `ADR_HUND) begin
      hold_reg <= time_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Command register, write-only
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cmd_reg <= cmd_s'(`CMD_RST);
    end else if (wr_en && adr_eff == `ADR_CMD) begin
      cmd_reg.test   <= WB_DAT_IN[`CMD_TEST_BIT];
      cmd_reg.ien    <= WB_DAT_IN[`CMD_IEN_BIT];
      cmd_reg.run    <= WB_DAT_IN[`CMD_RUN_BIT];
      cmd_reg.mode24 <= WB_DAT_IN[`CMD_24H_BIT];
      cmd_reg.xtal   <= xtal_sel_e'(WB_DAT_IN[1:0]);
    end
  end

  // Mask also picks which periodic rates may interrupt
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      imask_reg <= `IMASK_RST;
    end else if (wr_en && adr_eff == `ADR_IMASK) begin
      imask_reg <= {1'b0, WB_DAT_IN[`IRQ_SRC_W-1:0]};
    end
  end

  // ----------------------------------------------------------------------
  // Crystal divider
  // ----------------------------------------------------------------------
  rtc_prescaler u_prescaler (
    .clk_in      (CORE_CLK_IN),
    .nrst_in     (NRST_IN),
    .osc_tick_in (OSC_TICK_IN),
    .xtal_in     (cmd_reg.xtal),
    .run_in      (cmd_reg.run),
    .test_in     (cmd_reg.test),
    .tick_out    (tick)
  );

  // ----------------------------------------------------------------------
  // Counter chain
  // ----------------------------------------------------------------------
  assign date_max = month_days(time_reg.month, time_reg.year);
  assign c_sec    = tick && time_reg.hund == `HUND_MAX;
  assign c_min    = c_sec && time_reg.sec == `MINSEC_MAX;
  assign c_hour   = c_min && time_reg.min == `MINSEC_MAX;
  assign c_day    = c_hour && time_reg.hour == `HOUR_MAX;
  assign c_month  = c_day && time_reg.date >= date_max;
  assign c_year   = c_month && time_reg.month == `MONTH_MAX;

  // Each field wraps and carries into the next; no tick while stopped
  always_comb begin
    time_next = time_reg;
    if (tick) begin
      time_next.hund = c_sec ? 7'd0 : time_reg.hund + 7'd1;
    end
    if (c_sec) begin
      time_next.sec = (time_reg.sec == `MINSEC_MAX) ? 6'd0 : time_reg.sec + 6'd1;
    end
    if (c_min) begin
      time_next.min = (time_reg.min == `MINSEC_MAX) ? 6'd0 : time_reg.min + 6'd1;
    end
    if (c_hour) begin
      time_next.hour = (time_reg.hour == `HOUR_MAX) ? 5'd0 : time_reg.hour + 5'd1;
    end
    if (c_day) begin
      time_next.dow  = (time_reg.dow == `DOW_MAX) ? 3'd0 : time_reg.dow + 3'd1;
      time_next.date = c_month ? 5'd1 : time_reg.date + 5'd1;
    end
    if (c_month) begin
      time_next.month = c_year ? 4'd1 : time_reg.month + 4'd1;
    end
    if (c_year) begin
      time_next.year = (time_reg.year == `YEAR_MAX) ? 7'd0 : time_reg.year + 7'd1;
    end
  end

  // Host write to a counter wins over the carry into that field
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      time_reg       <= '0;
      time_reg.month <= 4'd1;
      time_reg.date  <= 5'd1;
    end else begin
      time_reg <= time_next;
      if (wr_en) begin
        case (adr_eff)
          `ADR_HUND:  time_reg.hund  <= WB_DAT_IN[6:0];
          `ADR_HOUR:  time_reg.hour  <= hour_wr;
          `ADR_MIN:   time_reg.min   <= WB_DAT_IN[5:0];
          `ADR_SEC:   time_reg.sec   <= WB_DAT_IN[5:0];
          `ADR_MONTH: time_reg.month <= WB_DAT_IN[3:0];
          `ADR_DATE:  time_reg.date  <= WB_DAT_IN[4:0];
          `ADR_YEAR:  time_reg.year  <= WB_DAT_IN[6:0];
          `ADR_DOW:   time_reg.dow   <= WB_DAT_IN[2:0];
          default:    ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Alarm store and comparator
  // ----------------------------------------------------------------------
  assign time_fld[0] = time_reg.hund;
  assign time_fld[1] = {2'b00, time_reg.hour};
  assign time_fld[2] = {1'b0, time_reg.min};
  assign time_fld[3] = {1'b0, time_reg.sec};
  assign time_fld[4] = {3'b000, time_reg.month};
  assign time_fld[5] = {2'b00, time_reg.date};
  assign time_fld[6] = time_reg.year;
  assign time_fld[7] = {4'h0, time_reg.dow};

  // Per field: value bits of its width plus an ignore bit, 51 bits in all
  for (genvar i = 0; i < 8; i++) begin : g_alarm
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
        alarm_val_reg[i] <= 7'h00;
        alarm_ign_reg[i] <= 1'b0;
      end else if (wr_en && adr_eff == (`ADR_ALARM_BASE + 5'(i))) begin
        if (i == 1) begin
          // Hours keep bit 7 for PM, so the ignore flag moves to bit 6
          alarm_val_reg[i] <= {2'b00, hour_wr};
          alarm_ign_reg[i] <= WB_DAT_IN[`ALARM_HR_IGN];
        end else begin
          alarm_val_reg[i] <= WB_DAT_IN[6:0] & FLD_MASK[i];
          alarm_ign_reg[i] <= WB_DAT_IN[`ALARM_IGN_BIT];
        end
      end
    end
    assign fld_eq[i] = alarm_ign_reg[i] || (alarm_val_reg[i] == time_fld[i]);
  end

  // Compare one cycle after the counters moved, so one hit per new time
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      adv_reg   <= 1'b0;
    end else begin
      adv_reg   <= tick;
    end
  end

  assign alarm_hit = adv_reg && (&fld_eq);

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  assign irq_ev[`IRQ_ALARM_BIT] = alarm_hit;
  assign irq_ev[`IRQ_HUND_BIT]  = tick;
  assign irq_ev[`IRQ_TENTH_BIT] = tick && (time_reg.hund % 7'd10 == 7'd9);
  assign irq_ev[`IRQ_SEC_BIT]   = c_sec;
  assign irq_ev[`IRQ_MIN_BIT]   = c_min;
  assign irq_ev[`IRQ_HOUR_BIT]  = c_hour;
  assign irq_ev[`IRQ_DAY_BIT]   = c_day;

  // Sticky, write one to clear; a new event in the clear cycle survives
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      istat_reg <= 7'h00;
    end else if (wr_en && adr_eff == `ADR_ISTAT) begin
      istat_reg <= (istat_reg & ~WB_DAT_IN[6:0]) | irq_ev;
    end else begin
      istat_reg <= istat_reg | irq_ev;
    end
  end

  // Level outputs; the global enable gates everything
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      IRQ_OUT       <= 1'b0;
      IRQ_ALARM_OUT <= 1'b0;
    end else begin
      IRQ_OUT       <= cmd_reg.ien && |(istat_reg & imask_reg[6:0]);
      IRQ_ALARM_OUT <= cmd_reg.ien && istat_reg[`IRQ_ALARM_BIT]
                       && imask_reg[`IRQ_ALARM_BIT];
    end
  end

endmodule

// ---- testbench/rtc_checker.sv ----
/*
  Bus and interrupt checks of rtc_top, seen only at its ports.
  Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ns

module rtc_checker (
  input wire logic       CORE_CLK_IN,
  input wire logic       NRST_IN,
  input wire logic       WB_CYC_IN,
  input wire logic       WB_STB_IN,
  input wire logic       WB_WE_IN,
  input wire logic [4:0] WB_ADR_IN,
  input wire logic [7:0] WB_DAT_OUT,
  input wire logic       WB_ACK_OUT,
  input wire logic       ADDR_LATCH_IN,
  input wire logic       PWR_FAIL_IN,
  input wire logic       IRQ_OUT,
  input wire logic       IRQ_ALARM_OUT
);
  // --------------------------------------------------------------
  // Properties; reset cuts every one short
  // --------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  property p_ack_answer; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_ack_single; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack longer than a cycle");
  property p_ack_cause; !(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // Data lines carry a value only in a read's ack cycle
  property p_idle_data; !WB_ACK_OUT || $past(WB_WE_IN) |-> WB_DAT_OUT == 8'h00; endproperty
  a_idle_data: assert property (p_idle_data) else $error("data driven outside a read");
  property p_pf_data; WB_ACK_OUT && $past(PWR_FAIL_IN) |-> WB_DAT_OUT == 8'h00; endproperty
  a_pf_data: assert property (p_pf_data) else $error("read served during power loss");
  property p_cmd_hidden; WB_ACK_OUT && $past(WB_ADR_IN == 5'h11 && ADDR_LATCH_IN) |-> WB_DAT_OUT == 8'h00;
  endproperty
  a_cmd_hidden: assert property (p_cmd_hidden) else $error("command register readable");
  property p_alarm_irq; IRQ_ALARM_OUT |-> IRQ_OUT; endproperty
  a_alarm_irq: assert property (p_alarm_irq) else $error("alarm without interrupt");
  property p_hund_range; WB_ACK_OUT && $past(WB_ADR_IN == 5'h00 && ADDR_LATCH_IN) |-> WB_DAT_OUT <= 8'h63;
  endproperty
  a_hund_range: assert property (p_hund_range) else $error("hundredths beyond 99");

  c_write: cover property (WB_ACK_OUT && $past(WB_WE_IN));
  c_irq: cover property ($rose(IRQ_OUT));
  c_alarm: cover property ($rose(IRQ_ALARM_OUT));
endmodule

bind rtc_top rtc_checker chk (.CORE_CLK_IN, .NRST_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN,
  .WB_DAT_OUT, .WB_ACK_OUT, .ADDR_LATCH_IN, .PWR_FAIL_IN, .IRQ_OUT, .IRQ_ALARM_OUT);

// ---- testbench/rtc_host_model.sv ----
/*
  Host model: classic Wishbone master with an address latch strobe.
  Assumes its tasks are entered right after a rising clock edge.
*/
`timescale 1ns/1ns

module rtc_host_model (
  input  wire logic       clk_in,
  input  wire logic       ack_in,
  input  wire logic [7:0] dat_in,
  output logic            cyc_out,
  output logic            stb_out,
  output logic            we_out,
  output logic      [4:0] adr_out,
  output logic      [0:0] sel_out,
  output logic      [7:0] dat_out,
  output logic            ale_out,
  output logic            hung_out
);
  // Idle bus, direct addressing by default
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 5'h00;
    sel_out = 1'b1;
    dat_out = 8'h00;
    ale_out = 1'b1;
    hung_out = 1'b0;
  end

  // One classic cycle, held until ack is sampled; wait is bounded
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= w;
    adr_out <= a;
    dat_out <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack_in !== 1'b1 && n < 64);
    hung_out <= (ack_in !== 1'b1);
    q = dat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    adr_out <= ~a; // Released lines must not keep stale values
    dat_out <= ~d;
    @(posedge clk_in);
  endtask

  // Multiplexed mode: address phase, then address lines scrambled
  task automatic latch(input logic [4:0] a);
    ale_out <= 1'b1;
    adr_out <= a;
    @(posedge clk_in);
    ale_out <= 1'b0;
    adr_out <= ~a;
    @(posedge clk_in);
  endtask

  task automatic direct();
    ale_out <= 1'b1;
    @(posedge clk_in);
  endtask
endmodule

// ---- testbench/test_bus_rtc_alarm_periodic_irq.sv ----
/*
  Self-checking bench of rtc_top: bus traffic through the host model,
  crystal pulses and power loss driven here. Assumes the defs header.
*/
`timescale 1ns/1ns
`include "rtc_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module test_bus_rtc_alarm_periodic_irq
  import rtc_pkg::*;
;
  logic       clk, nrst, osc, pf, cyc, stb, we, ale, hung, ack, irq, irq_al;
  logic [4:0] adr;
  logic [0:0] sel;
  logic [7:0] wdat, rdat;
  int         errors, comparisons;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  rtc_top uut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .ADDR_LATCH_IN(ale), .OSC_TICK_IN(osc), .PWR_FAIL_IN(pf), .IRQ_OUT(irq), .IRQ_ALARM_OUT(irq_al));
  rtc_host_model host (.clk_in(clk), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc), .stb_out(stb),
    .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat), .ale_out(ale), .hung_out(hung));

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Lost ack counts as a mismatch
  always @(posedge clk) begin
    if (hung === 1'b1) begin
      errors++;
      end_of_test();
    end
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    host.xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic chk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    `CHK(q, e)
  endtask
  // Crystal pulses two cycles apart, then margin for tick and status
  task automatic pulse(input int n);
    repeat (n) begin
      osc <= 1'b1;
      @(posedge clk);
      osc <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  initial begin
    logic [7:0] q;
    logic [7:0] v [7];
    static logic [7:0] tv [3][6] = '{'{8'h04, 8'h1D, 8'h03, 8'h01, 8'h02, 8'h01},
      '{8'h03, 8'h1C, 8'h03, 8'h01, 8'h00, 8'h00}, '{8'h04, 8'h1C, 8'h02, 8'h1D, 8'h02, 8'h01}};
    static int xt [6][3] = '{'{0, 327, 0}, '{0, 328, 1}, '{1, 10485, 0}, '{1, 10486, 1},
      '{2, 328, 0}, '{3, 328, 0}};
    nrst = 1'b0;
    osc = 1'b0;
    pf = 1'b0;
    errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(`ADR_HUND, 8'h00);
    chk(`ADR_MONTH, 8'h01);
    chk(`ADR_IMASK, 8'h00);
    chk(`ADR_CMD, 8'h00);
    chk(5'h1F, 8'h00);
    $display("test reset done");
    // Hold keeps the old snapshot until hundredths is read again
    wr(`ADR_MIN, 8'h2A);
    chk(`ADR_MIN, 8'h00);
    chk(`ADR_HUND, 8'h00);
    chk(`ADR_MIN, 8'h2A);
    wr(`ADR_MIN, 8'h05);
    chk(`ADR_MIN, 8'h2A);
    host.latch(`ADR_MIN);
    chk(5'h1F, 8'h2A);
    host.direct();
    $display("test snapshot done");
    // 3 PM written in 12 hour mode, read in both modes
    wr(`ADR_HOUR, 8'h83);
    chk(`ADR_HUND, 8'h00);
    chk(`ADR_HOUR, 8'h83);
    wr(`ADR_CMD, 8'h04);
    chk(`ADR_HUND, 8'h00);
    chk(`ADR_HOUR, 8'h0F);
    $display("test hours done");
    // Full carry chain into the calendar, leap and common years
    for (int i = 0; i < 3; i++) begin
      v = '{8'h63, 8'h17, 8'h3B, 8'h3B, 8'h02, tv[i][1], tv[i][0]};
      for (int k = 0; k < 7; k++) wr(5'(k), v[k]);
      wr(`ADR_IMASK, tv[i][4]);
      wr(`ADR_ISTAT, 8'hFF);
      wr(`ADR_CMD, 8'h3C);
      pulse(1);
      `CHK(irq, tv[i][5][0])
      chk(`ADR_HUND, 8'h00);
      chk(`ADR_HOUR, 8'h00);
      chk(`ADR_MONTH, tv[i][2]);
      chk(`ADR_DATE, tv[i][3]);
      rd(`ADR_ISTAT, q);
      `CHK(q & 8'hFE, 8'hFE)
      wr(`ADR_ISTAT, 8'hFF);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      wr(`ADR_CMD, 8'h04);
    end
    $display("test carry done");
    // Alarm on hundredths only, every other field ignored
    for (int k = 0; k < 8; k++) wr(5'(`ADR_ALARM_BASE + k), k == 0 ? 8'h05 : (k == 1 ? 8'h40 : 8'h80));
    chk(`ADR_ALARM_BASE, 8'h05);
    wr(`ADR_HUND, 8'h04);
    wr(`ADR_IMASK, 8'h01);
    wr(`ADR_ISTAT, 8'hFF);
    wr(`ADR_CMD, 8'h3C);
    pulse(1);
    `CHK(irq_al, 1'b1)
    wr(`ADR_CMD, 8'h04);
    rd(`ADR_ISTAT, q);
    `CHK(q & 8'h81, 8'h81)
    $display("test alarm done");
    // Power loss: access blocked, time keeps running
    wr(`ADR_CMD, 8'h3C);
    pf <= 1'b1;
    wr(`ADR_MIN, 8'h11);
    chk(`ADR_HUND, 8'h00);
    pulse(2);
    pf <= 1'b0;
    wr(`ADR_CMD, 8'h04);
    chk(`ADR_HUND, 8'h07);
    chk(`ADR_MIN, 8'h00);
    $display("test power done");
    // 32K and 1M codes against their divide boundary, 2M and 4M only below theirs
    for (int i = 0; i < 6; i++) begin
      wr(`ADR_CMD, 8'h04);
      wr(`ADR_HUND, 8'h00);
      wr(`ADR_CMD, 8'h0C | 8'(xt[i][0]));
      pulse(xt[i][1]);
      wr(`ADR_CMD, 8'h04);
      chk(`ADR_HUND, 8'(xt[i][2]));
    end
    $display("test crystal done");
    end_of_test();
  end
endmodule
